/* src/dsp_pkg.sv */
// shared constants of the two-word-burst separate-io sram port
// assumes both ends run on one 250 mhz clock and import this package
package dsp_pkg;

  // ***********************************************************
  // widths (wide variant)
  // ***********************************************************
  localparam int DATA_W = 36;
  localparam int ADDR_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int BURST = 2;
  localparam int DEPTH = 1 << ADDR_W;

  // ***********************************************************
  // timing and buffering
  // ***********************************************************
  localparam int CLK_MHZ = 250;
  localparam int RD_W0_EDGE = 4;
  localparam int RD_PIPE_W = RD_W0_EDGE + 1;
  localparam int RSP_DEPTH = 2;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [LANES-1:0] BWS_IDLE = 4'hf;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0;

endpackage

/* src/dsp_link_if.sv */
// link between the memory controller end and the sram end
// assumes both ends share ref_clk; the read bus wire is resolved here
`timescale 1ns/10ps
interface dsp_link_if;
  import dsp_pkg::*;

  // ***********************************************************
  // controller driven
  // ***********************************************************
  logic k_clk;
  logic k_clk_n;
  logic c_clk;
  logic c_clk_n;
  logic cycle_load_n;
  logic rd_wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [LANES-1:0] byte_write_sel_n;

  // ***********************************************************
  // sram driven
  // ***********************************************************
  logic [DATA_W-1:0] rd_data;
  logic rd_oe;
  logic echo_clk;
  logic echo_clk_n;
  wire [DATA_W-1:0] rd_q;

  // rd_oe is the pad enable of the read port; while it is low the bus
  // shows the inverse of the last word, so a capture at the wrong edge reads bad data
  assign rd_q = rd_oe ? rd_data : ~rd_data;

  modport dev (
    input k_clk, k_clk_n, c_clk, c_clk_n, cycle_load_n, rd_wr, addr, wr_data,
    input byte_write_sel_n,
    output rd_data, rd_oe, echo_clk, echo_clk_n
  );

  modport ctl (
    output k_clk, k_clk_n, c_clk, c_clk_n, cycle_load_n, rd_wr, addr, wr_data,
    output byte_write_sel_n,
    input rd_q, echo_clk, echo_clk_n
  );
endinterface

/* src/dsp_sram_dev.sv */
// sram end of the two-word-burst separate-io port: input capture,
// byte-masked burst writes, read pipeline, read bus enable (inverted word when off), echo clock
// assumes the far end makes k/c as a phase level on ref_clk, c in phase with k
`timescale 1ns/10ps
module dsp_sram_dev (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  dsp_link_if.dev link,
  output logic single_clk_mode_o,
  output logic rd_active_o
);
  import dsp_pkg::*;

  // ***********************************************************
  // decoding helpers
  // ***********************************************************

  // expand active-low byte selects to a per-bit write mask
  function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] sel_n);
    logic [DATA_W-1:0] m;
    m = DATA_RST;
    for (int i = 0; i < LANES; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{~sel_n[i]}};
    end
    return m;
  endfunction

  // keep old bits where the mask is clear
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [DATA_W-1:0] m);
    return (old_w & ~m) | (new_w & m);
  endfunction

  // ***********************************************************
  // phase decode
  // ***********************************************************

  logic k_edge;
  logic kn_edge;
  logic launch_pos;
  logic single_reg;

  // a sampled k level of one marks a positive input edge
  assign k_edge = link.k_clk;
  assign kn_edge = ~link.k_clk;

  // single clock mode when c and c_n are both tied to the same level
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      single_reg <= 1'b0;
    end else if (ce_i) begin
      single_reg <= (link.c_clk == link.c_clk_n);
    end
  end

  assign single_clk_mode_o = single_reg;

  // launch clock: output clock pair, or input clock in single mode
  assign launch_pos = single_reg ? link.k_clk : link.c_clk;

  // ***********************************************************
  // storage: two full-depth arrays, one per burst word
  // ***********************************************************

  logic [DATA_W-1:0] mem_even [DEPTH];
  logic [DATA_W-1:0] mem_odd [DEPTH];

  // ***********************************************************
  // load capture on the positive input phase
  // ***********************************************************

  logic ld_rd_reg;
  logic ld_wr_reg;
  logic [ADDR_W-1:0] ld_addr_reg;
  logic [DATA_W-1:0] wr_w0_reg;
  logic [DATA_W-1:0] wr_m0_reg;
  logic load;

  // only a low strobe on a k edge opens a transaction
  assign load = k_edge & ~link.cycle_load_n;

  // direction and address are taken together with the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ld_rd_reg <= 1'b0;
      ld_wr_reg <= 1'b0;
      ld_addr_reg <= ADDR_RST;
    end else if (ce_i && k_edge) begin
      ld_rd_reg <= load & link.rd_wr;
      ld_wr_reg <= load & ~link.rd_wr;
      if (load) begin
        ld_addr_reg <= link.addr;
      end
    end
  end

  // first write word and its byte selects ride the same k edge
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wr_w0_reg <= DATA_RST;
      wr_m0_reg <= DATA_RST;
    end else if (ce_i && load && !link.rd_wr) begin
      wr_w0_reg <= link.wr_data;
      wr_m0_reg <= lane_mask(link.byte_write_sel_n);
    end
  end

  // ***********************************************************
  // write commit on the negative input phase
  // ***********************************************************

  // second word is taken here and both words land at once, so a
  // burst is never half written; arrays hold no reset on purpose
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && kn_edge && ld_wr_reg) begin
      mem_even[ld_addr_reg] <= merge(mem_even[ld_addr_reg], wr_w0_reg,
                                     wr_m0_reg);
      mem_odd[ld_addr_reg] <= merge(mem_odd[ld_addr_reg], link.wr_data,
                                    lane_mask(link.byte_write_sel_n));
    end
  end

  // ***********************************************************
  // read fetch on the negative input phase
  // ***********************************************************

  logic pend_vld_reg;
  logic [DATA_W-1:0] pend0_reg;
  logic [DATA_W-1:0] pend1_reg;

  // fetch shares the edge with a write commit; a read of the same
  // pair in that edge sees the old contents
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pend_vld_reg <= 1'b0;
      pend0_reg <= DATA_RST;
      pend1_reg <= DATA_RST;
    end else if (ce_i && kn_edge) begin
      pend_vld_reg <= ld_rd_reg;
      if (ld_rd_reg) begin
        pend0_reg <= mem_even[ld_addr_reg];
        pend1_reg <= mem_odd[ld_addr_reg];
      end
    end
  end

  // ***********************************************************
  // read launch and bus enable
  // ***********************************************************

  logic [DATA_W-1:0] q_reg;
  logic oe_reg;

  // word 0 on the positive launch phase, word 1 on the negative;
  // enable falls on the next positive phase with nothing pending
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      q_reg <= DATA_RST;
      oe_reg <= 1'b0;
    end else if (ce_i) begin
      if (launch_pos) begin
        oe_reg <= pend_vld_reg;
        if (pend_vld_reg) begin
          q_reg <= pend0_reg;
        end
      end else if (oe_reg) begin
        q_reg <= pend1_reg;
      end
    end
  end

  assign link.rd_data = q_reg;
  assign link.rd_oe = oe_reg;
  assign rd_active_o = oe_reg;

  // ***********************************************************
  // echo clocks
  // ***********************************************************

  logic echo_reg;
  logic echo_n_reg;

  // runs even with no reads so the controller can lock onto it
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      echo_reg <= 1'b0;
      echo_n_reg <= 1'b1;
    end else if (ce_i) begin
      echo_reg <= launch_pos;
      echo_n_reg <= ~launch_pos;
    end
  end

  assign link.echo_clk = echo_reg;
  assign link.echo_clk_n = echo_n_reg;

  // ***********************************************************
  // notes
  // ***********************************************************

  // limitation: launch and capture assume c in phase with k;
  // a skewed c would shift the read by whole cycles, not deskew it.
  // the controller end and this end must share ce_i, or the phase
  // levels seen here stop matching the edges the controller counts.

endmodule

/* src/dsp_sram_ctl.sv */
// memory controller end: issues two-word bursts, times read capture,
// and buffers returned pairs in a two-entry queue
// assumes the user side runs on ref_clk and holds a request until taken
`timescale 1ns/10ps
module dsp_sram_ctl (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic single_clk_mode_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_read_i,
  input wire logic [dsp_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [2*dsp_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic [2*dsp_pkg::LANES-1:0] req_byte_en_i,
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [2*dsp_pkg::DATA_W-1:0] rsp_rdata_o,
  dsp_link_if.ctl link
);
  import dsp_pkg::*;

  // count reads still on their way back
  function automatic logic [2:0] in_flight(input logic [RD_PIPE_W-1:0] p);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < RD_PIPE_W; i++) begin
      n = n + {2'h0, p[i]};
    end
    return n;
  endfunction

  // ***********************************************************
  // clock generation
  // ***********************************************************

  logic k_reg;

  // k toggles every cycle; one link period is two ref cycles
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      k_reg <= 1'b0;
    end else if (ce_i) begin
      k_reg <= ~k_reg;
    end
  end

  assign link.k_clk = k_reg;
  assign link.k_clk_n = ~k_reg;
  // single mode ties both output clocks high
  assign link.c_clk = single_clk_mode_i | k_reg;
  assign link.c_clk_n = single_clk_mode_i | ~k_reg;

  // ***********************************************************
  // request issue
  // ***********************************************************

  logic [RD_PIPE_W-1:0] pipe_reg;
  logic [1:0] cnt_reg;
  logic slot;
  logic room;
  logic fire;
  logic [DATA_W-1:0] hi_word_reg;
  logic [LANES-1:0] hi_bws_reg;
  logic load_n_reg;
  logic rw_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wd_reg;
  logic [LANES-1:0] bws_reg;

  // a read is only issued if its pair is sure of a queue entry
  assign slot = ~k_reg;
  assign room = ({1'b0, cnt_reg} + in_flight(pipe_reg)) < 3'(RSP_DEPTH);
  assign req_ready_o = ce_i & slot & (~req_read_i | room);
  assign fire = req_valid_i & req_ready_o;

  // load, direction and address stand in the k-phase cycle together
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      load_n_reg <= 1'b1;
      rw_reg <= 1'b0;
      addr_reg <= ADDR_RST;
      wd_reg <= DATA_RST;
      bws_reg <= BWS_IDLE;
      hi_word_reg <= DATA_RST;
      hi_bws_reg <= BWS_IDLE;
    end else if (ce_i) begin
      if (slot) begin
        load_n_reg <= ~fire;
        bws_reg <= BWS_IDLE;
        if (fire) begin
          rw_reg <= req_read_i;
          addr_reg <= req_addr_i;
          wd_reg <= req_wdata_i[DATA_W-1:0];
          hi_word_reg <= req_wdata_i[2*DATA_W-1:DATA_W];
          if (!req_read_i) begin
            bws_reg <= ~req_byte_en_i[LANES-1:0];
            hi_bws_reg <= ~req_byte_en_i[2*LANES-1:LANES];
          end
        end
      end else begin
        // second beat of the burst on the negative phase
        load_n_reg <= 1'b1;
        wd_reg <= hi_word_reg;
        bws_reg <= hi_bws_reg;
        hi_bws_reg <= BWS_IDLE;
      end
    end
  end

  assign link.cycle_load_n = load_n_reg;
  assign link.rd_wr = rw_reg;
  assign link.addr = addr_reg;
  assign link.wr_data = wd_reg;
  assign link.byte_write_sel_n = bws_reg;

  // ***********************************************************
  // read capture at a fixed edge count
  // ***********************************************************

  logic [DATA_W-1:0] cap_lo_reg;
  logic push;
  logic pop;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pipe_reg <= 5'h00;
    end else if (ce_i) begin
      pipe_reg <= {pipe_reg[RD_PIPE_W-2:0], fire & req_read_i};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cap_lo_reg <= DATA_RST;
    end else if (ce_i && pipe_reg[RD_W0_EDGE-1]) begin
      cap_lo_reg <= link.rd_q;
    end
  end

  assign push = ce_i & pipe_reg[RD_W0_EDGE];
  assign pop = ce_i & rsp_valid_o & rsp_ready_i;

  // ***********************************************************
  // two-entry response queue
  // ***********************************************************

  logic [2*DATA_W-1:0] q_mem [RSP_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;

  // credit check above guarantees push never meets a full queue
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      q_mem[wr_ptr_reg] <= {link.rd_q, cap_lo_reg};
    end
  end

  assign rsp_valid_o = (cnt_reg != 2'h0);
  assign rsp_rdata_o = q_mem[rd_ptr_reg];

endmodule

/* testbench/dsp_link_chk.sv */
// link checker for the two-word-burst sram port
// assumes it sits beside the link interface, one clock, sync low reset
`timescale 1ns/10ps
module dsp_link_chk (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic k_clk,
  input wire logic cycle_load_n,
  input wire logic rd_wr,
  input wire logic [dsp_pkg::LANES-1:0] byte_write_sel_n,
  input wire logic rd_oe,
  input wire logic echo_clk,
  input wire logic echo_clk_n
);
  import dsp_pkg::*;
  logic rd_ld;
  logic wr_ld;

  // ***********************************************************
  // load decode
  // ***********************************************************
  // a load only counts on a positive input phase
  assign rd_ld = !cycle_load_n && rd_wr && k_clk;
  assign wr_ld = !cycle_load_n && !rd_wr && k_clk;

  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence rd_ld_s;
    rd_ld;
  endsequence
  sequence rd_alone_s;
    rd_ld ##2 !rd_ld;
  endsequence

  // ***********************************************************
  // properties
  // ***********************************************************
  load_on_k_a: assert property (!cycle_load_n |-> k_clk)
    else $error("load strobe seen on negative phase");
  single_load_a: assert property (!cycle_load_n |=> cycle_load_n)
    else $error("load strobe held two cycles");
  read_burst_a: assert property (rd_ld_s |-> ##3 rd_oe ##1 rd_oe)
    else $error("read words not driven at fixed latency");
  read_end_a: assert property (rd_alone_s |-> ##3 !rd_oe)
    else $error("read bus driven past two words");
  oe_cause_a: assert property (rd_oe |-> $past(rd_ld, 3) || $past(rd_ld, 4))
    else $error("read bus driven without a loaded read");
  write_no_oe_a: assert property (wr_ld |-> ##3 !rd_oe)
    else $error("write load drove the read bus");
  bws_idle_a: assert property (cycle_load_n && $past(cycle_load_n) |->
    byte_write_sel_n == BWS_IDLE)
    else $error("byte selects active outside a write");
  echo_pair_a: assert property (echo_clk_n == !echo_clk)
    else $error("echo clocks not complementary");
endmodule

/* testbench/ddr_separate_io_sram_port_test.sv */
// self-checking bench: controller end and sram end joined by the link
// assumes both ends share ref_clk; a queue model predicts read data
`timescale 1ns/10ps
module ddr_separate_io_sram_port_test;
  import dsp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_read_i = 1'b0;
  logic single_mode = 1'b0;
  logic rsp_ready_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [2*DATA_W-1:0] req_wdata_i = '0;
  logic [2*LANES-1:0] req_byte_en_i = '0;
  logic req_ready_o;
  logic rsp_valid_o;
  logic [2*DATA_W-1:0] rsp_rdata_o;
  logic single_clk_mode_o;
  logic rd_active_o;
  int num_errors = 0;
  int n_checks = 0;
  bit stall = 1'b1;
  logic [71:0] mem [logic [17:0]];
  logic [71:0] expq[$];
  logic [17:0] pool [8];

  // ***********************************************************
  // clock and instances
  // ***********************************************************
  always #2 ref_clk_i = ~ref_clk_i;

  dsp_link_if link();
  dsp_sram_dev i_dsp_sram_dev (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .link(link), .single_clk_mode_o(single_clk_mode_o), .rd_active_o(rd_active_o));
  dsp_sram_ctl i_dsp_sram_ctl (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .single_clk_mode_i(single_mode), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_read_i(req_read_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_byte_en_i(req_byte_en_i), .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
    .rsp_rdata_o(rsp_rdata_o), .link(link));
  dsp_link_chk i_dsp_link_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .k_clk(link.k_clk),
    .cycle_load_n(link.cycle_load_n), .rd_wr(link.rd_wr),
    .byte_write_sel_n(link.byte_write_sel_n), .rd_oe(link.rd_oe),
    .echo_clk(link.echo_clk), .echo_clk_n(link.echo_clk_n));

  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic check(string name, logic [71:0] seen, logic [71:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // holds the request until taken, then updates the model; valid stays up
  task issue(bit rd, logic [17:0] a, logic [71:0] wd, logic [7:0] be);
    int i;
    int j;
    logic [71:0] t;
    req_valid_i = 1'b1;
    req_read_i = rd;
    req_addr_i = a;
    req_wdata_i = wd;
    req_byte_en_i = be;
    for (i = 0; i < 60; i++) begin
      #1;
      if (req_ready_o === 1'b1) break;
      @(posedge ref_clk_i);
      #1;
    end
    if (i == 60) begin
      check("req_ready_timeout", 0, 1);
      summarize();
    end
    @(posedge ref_clk_i);
    #1;
    if (rd) begin
      expq.push_back(mem[a]);
    end else begin
      t = mem.exists(a) ? mem[a] : 72'hx;
      // a cleared enable keeps the stored lane
      for (j = 0; j < 8; j++) if (be[j]) t[9*j +: 9] = wd[9*j +: 9];
      mem[a] = t;
    end
  endtask

  // ***********************************************************
  // response side: random stalls, compare at every pop
  // ***********************************************************
  always begin
    @(posedge ref_clk_i);
    #1;
    rsp_ready_i = !stall && ($urandom % 4 != 0);
    #1;
    if (rsp_valid_o === 1'b1 && rsp_ready_i) begin
      if (expq.size() == 0) check("rsp_extra", 1, 0);
      else check("rsp_rdata", rsp_rdata_o, expq.pop_front());
    end
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    int k;
    int m;
    int lat;
    void'($urandom(53810));
    repeat (16) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    check("rd_oe_idle", 72'(link.rd_oe), 72'h0);
    check("rd_active", rd_active_o, 0);
    // boundary addresses plus random ones, all filled with full writes
    pool[0] = 18'h0;
    pool[1] = 18'h3ffff;
    for (k = 2; k < 8; k++) pool[k] = 18'($urandom);
    for (k = 0; k < 8; k++) issue(0, pool[k], 72'({$urandom, $urandom, $urandom}), 8'hff);
    // read latency with an empty queue and no pops
    issue(1, pool[0], '0, '0);
    req_valid_i = 1'b0;
    for (lat = 0; lat < 20 && rsp_valid_o !== 1'b1; lat++) begin
      @(posedge ref_clk_i);
      #1;
    end
    check("rsp_latency", 72'(lat), 72'd5);
    // second read fills the queue, a third must be refused
    issue(1, pool[1], '0, '0);
    req_valid_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    req_valid_i = 1'b1;
    req_addr_i = pool[2];
    lat = 0;
    repeat (12) begin
      @(posedge ref_clk_i);
      #1;
      if (req_ready_o !== 1'b0) lat++;
    end
    check("ready_when_full", 72'(lat), 72'd0);
    stall = 1'b0;
    issue(1, pool[2], '0, '0);
    req_valid_i = 1'b0;
    // random back-to-back mix in both clock modes
    for (m = 0; m < 2; m++) begin
      repeat (12) @(posedge ref_clk_i);
      #1;
      single_mode = m[0];
      repeat (4) @(posedge ref_clk_i);
      #1;
      check("single_mode", single_clk_mode_o, 72'(m));
      for (k = 0; k < 60; k++) begin
        issue($urandom % 2, pool[$urandom % 8], 72'({$urandom, $urandom, $urandom}),
          8'($urandom));
      end
      req_valid_i = 1'b0;
    end
    for (k = 0; k < 100 && (expq.size() != 0 || rsp_valid_o === 1'b1); k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    check("drained", 72'(expq.size()), 72'd0);
    check("rd_oe_end", 72'(link.rd_oe), 72'h0);
    summarize();
  end
endmodule
